// [hdl/lds_map.svh]
// Purpose: constants for the led string dimming sequencer
// Assumes: 10 MHz core clock
// Notes: times in ns, cycle counts derived from them
// How it works
// - active sinks follow the dimming pwm level
// - pwm-only: long low stops the regulator
// - enable low forces strings and regulator off
// - normal mode: all strings switch in phase
// - four strings: 0, 90, 180, 270 degrees
// - three strings: 0, 120, 240; sink four idle
// - sinks one and three: half period apart
// - ganged pairs, second pair 180 degrees later
// - unsupported arrangement falls back to in-phase
// - pull-up value picks normal or sequenced
// - hybrid: dimming input gates analog-set current
// - hybrid: sequenced only by factory preset
// - hybrid: long low stops the regulator
// - analog: dimming input low turns all off
// - more than 32 cycles out of regulation flags overload
// - dimming mode latched once after reset
// - fault: auto-restart stop, or latch-off request
`ifndef LDS_MAP_SVH
`define LDS_MAP_SVH
`define LDS_CLK_PERIOD_NS 100
`define LDS_MIN_PWM_PERIOD_NS 10000000
`define LDS_MIN_PWM_PERIOD_CYC (`LDS_MIN_PWM_PERIOD_NS / `LDS_CLK_PERIOD_NS)
`define LDS_OVL_CYCLES 32
`define LDS_CFG_FOUR 4'hF
`define LDS_CFG_THREE 4'h7
`define LDS_CFG_ONE_THREE 4'h5
`define LDS_CFG_GANGED 4'hF
`endif

// [hdl/lds_ovl_if.sv]
// Purpose: carrier between top and the overload watcher
// Assumes: one clock
// Notes: three rails, one bit each
`timescale 1ns/1ps
interface lds_ovl_if;
   logic [2:0] low;
   logic [2:0] flag;
   modport top (output low, input flag);
   modport mon (input low, output flag);
endinterface : lds_ovl_if

// [hdl/lds_ovl_mon.sv]
// Purpose: counts switching cycles each rail spends below set point
// Assumes: cycle strobe and low levels already synchronised
// Notes: flag is sticky until reset
`timescale 1ns/1ps
`include "lds_map.svh"
module lds_ovl_mon
   import lds_pkg::*;
#(
   parameter int CYCLES = `LDS_OVL_CYCLES
) (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic sw_cycle_in,
   lds_ovl_if.mon ovl
);
   // the count saturates at 255, so a limit of 255 could never be passed
   if (CYCLES < 1 || CYCLES > 254) begin : g_bad_cycles
      $error("lds_ovl_mon: bad CYCLES");
   end
   typedef struct packed {
      logic [2:0][7:0] cnt;
      logic [2:0] flag;
   } lds_ovl_state_t;
   lds_ovl_state_t st, next_st;
   always_comb begin
      next_st = st;
      for (int i = 0; i < 3; i++) begin
         if (!ovl.low[i]) begin
            next_st.cnt[i] = 8'h00;
         end else if (sw_cycle_in && st.cnt[i] != 8'hFF) begin
            next_st.cnt[i] = st.cnt[i] + 8'h01;
         end
         // flag once the run passes the limit
         if (st.cnt[i] > 8'(CYCLES)) next_st.flag[i] = 1'b1;
      end
   end
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign ovl.flag = st.flag;
   ovl_set_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (st.cnt[0] > 8'(CYCLES)) |=> st.flag[0]) else $error("overload not flagged");
endmodule : lds_ovl_mon

// [hdl/lds_pkg.sv]
// Purpose: types for the led string dimming sequencer
// Assumes: nothing
// Notes: mode encodings left to the tool
package lds_pkg;
   typedef enum logic [1:0] {LDS_PWM_ONLY, LDS_ANALOG, LDS_HYBRID} lds_mode_t;
   typedef enum logic [1:0] {LDS_ST_BOOT, LDS_ST_RUN, LDS_ST_FAULT} lds_state_t;
endpackage : lds_pkg

// [hdl/lds_sequencer.sv]
// Purpose: gates four string sinks from the dimming pwm, in phase or sequenced
// Assumes: rail-low and switching-cycle inputs come from analog comparators
// Notes: sequencing lags one pwm period behind a period change
`timescale 1ns/1ps
`include "lds_map.svh"
module lds_sequencer
   import lds_pkg::*;
#(
   parameter int MIN_PERIOD_CYC = `LDS_MIN_PWM_PERIOD_CYC,
   parameter int CW = 20
) (
   // clock and reset
   input wire logic CLK_IN,
   input wire logic RESET_N_IN,
   // control pins
   input wire logic BACKLIGHT_ON_REQUEST_IN,
   input wire logic DIGITAL_DIM_INPUT_IN,
   // start-up straps
   input wire logic DIM_LEVEL_PIN_HIGH_IN,
   input wire logic SEQUENCE_SELECT_RESISTOR_IN,
   input wire logic FACTORY_SEQUENCE_PRESET_IN,
   input wire logic HYBRID_STRAP_IN,
   input wire logic LATCH_OFF_OPTION_IN,
   input wire logic STRAPS_VALID_IN,
   input wire logic [3:0] STRINGS_PRESENT_IN,
   input wire logic GANGED_PAIRS_IN,
   // rail monitor
   input wire logic SW_CYCLE_IN,
   input wire logic FIXED_RAIL_1_LOW_IN,
   input wire logic FIXED_RAIL_2_LOW_IN,
   input wire logic STRING_SUPPLY_RAIL_LOW_IN,
   // outputs
   output logic [3:0] STRING_SINK_OUT,
   output logic REGULATOR_ON_OUT,
   output logic SEQUENCED_OUT,
   output logic OVERLOAD_OUT,
   output logic STOP_REQUESTS_OUT,
   output logic LATCH_OFF_REQUEST_OUT
);
   // refuse a counter too narrow to hold the minimum period
   if (CW < 4 || CW > 30 || MIN_PERIOD_CYC < 1 || MIN_PERIOD_CYC >= (1 << CW)) begin : g_bad_cw
      $error("lds_sequencer: CW too small");
   end
   typedef struct packed {
      logic [1:0] en_s, dim_s;
      logic [2:0] cyc_s;
      logic [2:0] low_s1, low_s2;
      lds_state_t state;
      lds_mode_t mode;
      logic seq;
      logic [1:0] steps;
      logic dim_d;
      logic [CW-1:0] phase, period, high, low_cnt;
      logic [3:0] sink;
      logic reg_on, ovl, stop, latch;
   } lds_state_str_t;
   lds_state_str_t st, next_st;
   lds_ovl_if ovl_bus ();
   logic [3:0] win;
   logic [CW-1:0] off_k;
   logic dim, en, rise;
   assign dim = st.dim_s[1];
   assign en = st.en_s[1];
   assign rise = dim && !st.dim_d;
   assign ovl_bus.low = st.low_s2;
   lds_ovl_mon #(.CYCLES(`LDS_OVL_CYCLES)) u_ovl (
      .clk_in(CLK_IN),
      .reset_n_in(RESET_N_IN),
      // rising edge taken behind the second sync stage only
      .sw_cycle_in(st.cyc_s[1] && !st.cyc_s[2]),
      .ovl(ovl_bus)
   );
   // per-string window: on while phase sits in [k*P/n, k*P/n + H)
   always_comb begin
      win = 4'h0;
      off_k = '0;
      for (int k = 0; k < 4; k++) begin
         case (st.steps)
            2'd3: off_k = CW'((st.period * k) >> 2);
            2'd2: off_k = CW'((st.period * k) / 3);
            default: off_k = CW'((st.period * k) >> 1);
         endcase
         win[k] = (st.phase >= off_k) && (st.phase < off_k + st.high);
      end
   end
   always_comb begin
      next_st = st;
      next_st.en_s = {st.en_s[0], BACKLIGHT_ON_REQUEST_IN};
      next_st.dim_s = {st.dim_s[0], DIGITAL_DIM_INPUT_IN};
      next_st.cyc_s = {st.cyc_s[1:0], SW_CYCLE_IN};
      next_st.low_s1 = {STRING_SUPPLY_RAIL_LOW_IN, FIXED_RAIL_2_LOW_IN, FIXED_RAIL_1_LOW_IN};
      next_st.low_s2 = st.low_s1;
      next_st.dim_d = dim;
      // measure the incoming period and high time
      if (rise) begin
         // phase restarts at zero one cycle after the edge
         next_st.period = st.phase + 1'b1;
         next_st.phase = '0;
      end else if (st.phase != '1) begin
         next_st.phase = st.phase + 1'b1;
      end
      // the rising cycle itself is the first high cycle
      if (rise) next_st.high = CW'(1'b1);
      else if (dim && st.high != '1) next_st.high = st.high + 1'b1;
      if (dim) next_st.low_cnt = '0;
      else if (st.low_cnt != '1) next_st.low_cnt = st.low_cnt + 1'b1;
      case (st.state)
         LDS_ST_BOOT: begin
            next_st.sink = 4'h0;
            next_st.reg_on = 1'b0;
            if (STRAPS_VALID_IN) begin
               // mode held until the next power-on reset
               next_st.mode = DIM_LEVEL_PIN_HIGH_IN ? LDS_PWM_ONLY :
                  (HYBRID_STRAP_IN ? LDS_HYBRID : LDS_ANALOG);
               next_st.seq = 1'b0;
               if (DIM_LEVEL_PIN_HIGH_IN) next_st.seq = SEQUENCE_SELECT_RESISTOR_IN;
               else if (HYBRID_STRAP_IN) next_st.seq = FACTORY_SEQUENCE_PRESET_IN;
               next_st.steps = 2'd0;
               if (GANGED_PAIRS_IN && STRINGS_PRESENT_IN == `LDS_CFG_GANGED) begin
                  next_st.steps = 2'd1;
               end else if (STRINGS_PRESENT_IN == `LDS_CFG_FOUR) begin
                  next_st.steps = 2'd3;
               end else if (STRINGS_PRESENT_IN == `LDS_CFG_THREE) begin
                  next_st.steps = 2'd2;
               end else if (STRINGS_PRESENT_IN == `LDS_CFG_ONE_THREE) begin
                  next_st.steps = 2'd1;
               end else begin
                  next_st.seq = 1'b0;
               end
               next_st.state = LDS_ST_RUN;
            end
         end
         LDS_ST_RUN: begin
            next_st.reg_on = 1'b1;
            if (st.mode == LDS_ANALOG) begin
               next_st.sink = dim ? STRINGS_PRESENT_IN : 4'h0;
               next_st.reg_on = dim;
            end else begin
               if (!st.seq) begin
                  next_st.sink = dim ? STRINGS_PRESENT_IN : 4'h0;
               end else if (st.steps == 2'd1 && GANGED_PAIRS_IN) begin
                  next_st.sink = {win[1], win[1], win[0], win[0]} & STRINGS_PRESENT_IN;
               end else if (st.steps == 2'd1) begin
                  next_st.sink = {1'b0, win[1], 1'b0, win[0]} & STRINGS_PRESENT_IN;
               end else if (st.steps == 2'd2) begin
                  next_st.sink = {1'b0, win[2:0]} & STRINGS_PRESENT_IN;
               end else begin
                  next_st.sink = win & STRINGS_PRESENT_IN;
               end
            end
            // applied in every mode, so a long low always means regulator off
            if (st.low_cnt >= CW'(MIN_PERIOD_CYC)) next_st.reg_on = 1'b0;
            if (!en) begin
               next_st.sink = 4'h0;
               next_st.reg_on = 1'b0;
            end
            if (|ovl_bus.flag) begin
               next_st.ovl = 1'b1;
               next_st.state = LDS_ST_FAULT;
            end
         end
         default: begin
            next_st.sink = 4'h0;
            next_st.reg_on = 1'b0;
            // fault response chosen by option input
            next_st.stop = !LATCH_OFF_OPTION_IN;
            next_st.latch = LATCH_OFF_OPTION_IN;
         end
      endcase
   end
   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign STRING_SINK_OUT = st.sink;
   assign REGULATOR_ON_OUT = st.reg_on;
   assign SEQUENCED_OUT = st.seq;
   assign OVERLOAD_OUT = st.ovl;
   assign STOP_REQUESTS_OUT = st.stop;
   assign LATCH_OFF_REQUEST_OUT = st.latch;
   sequence en_low_s;
      !en;
   endsequence
   sequence all_off_s;
      st.sink == 4'h0 && !st.reg_on;
   endsequence
   enable_off_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
      en_low_s |=> all_off_s) else $error("enable low left sinks on");
   inphase_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
      (st.state == LDS_ST_RUN && !st.seq && en && st.mode != LDS_ANALOG)
      |=> st.sink == ($past(dim) ? STRINGS_PRESENT_IN : 4'h0))
      else $error("in-phase mismatch");
   dim_follow_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
      (st.state == LDS_ST_RUN && !st.seq && !dim) |=> st.sink == 4'h0)
      else $error("sink on while dim low");
   long_low_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
      (st.state == LDS_ST_RUN && st.low_cnt >= CW'(MIN_PERIOD_CYC)) |=> !st.reg_on)
      else $error("regulator kept on");
   analog_off_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
      (st.state == LDS_ST_RUN && st.mode == LDS_ANALOG && !dim) |=> all_off_s)
      else $error("analog dim low not honoured");
   mode_hold_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
      (st.state != LDS_ST_BOOT) |=> $stable(st.mode) && $stable(st.seq))
      else $error("mode changed after start-up");
   fallback_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
      (st.state == LDS_ST_BOOT && STRAPS_VALID_IN && STRINGS_PRESENT_IN != `LDS_CFG_FOUR
      && STRINGS_PRESENT_IN != `LDS_CFG_THREE && STRINGS_PRESENT_IN != `LDS_CFG_ONE_THREE)
      |=> !st.seq) else $error("no fallback to in-phase");
   fault_act_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
      (st.state == LDS_ST_FAULT) |=> (st.stop ^ st.latch)) else $error("no fault action");
endmodule : lds_sequencer

// [tb/lds_ctrl_model.sv]
// Purpose: display controller model driving the dimming and enable pins
// Assumes: one clock, pins change just after the rising edge
// Notes: blanks through the dimming input, never through a zero analog level
`timescale 1ns/1ps
module lds_ctrl_model (
   // control from the bench
   input wire logic clk_in,
   input wire logic run_in,
   input wire logic level_in,
   input wire logic enable_in,
   input wire logic [7:0] period_in,
   input wire logic [7:0] high_in,
   // pins towards the device
   output logic dim_out = 1'b0,
   output logic enable_out = 1'b0,
   output logic analog_duty_out = 1'b0
);
   logic [7:0] cnt = 8'h00;
   always @(posedge clk_in) begin
      cnt <= (cnt + 8'h01 >= period_in) ? 8'h00 : cnt + 8'h01;
      // a steady level outside pwm runs lets analog mode hold the input high
      dim_out <= run_in ? (cnt < high_in) : level_in;
      enable_out <= enable_in;
      // the analog level is a dc value here, so the duty input stays low
      analog_duty_out <= 1'b0;
   end
endmodule : lds_ctrl_model

// [tb/tb_led_string_dimming_sequencer.sv]
// Purpose: self-checking bench for the led string dimming sequencer
// Assumes: 10 MHz clock, short minimum pwm period for simulation
// Notes: phases measured between sink rising edges, free of pipeline delay
`timescale 1ns/1ps
module tb_led_string_dimming_sequencer;
   import lds_pkg::*;
   localparam int P = 48;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic run = 1'b0, lvl = 1'b0, en = 1'b1, dim, ena;
   logic pin_hi = 1'b1, seq_res = 1'b0, fact = 1'b0, hyb = 1'b0;
   logic latch = 1'b0, valid = 1'b0, gang = 1'b0, swc = 1'b0;
   logic [3:0] strings = 4'hF;
   logic [2:0] rail = 3'h0;
   logic [3:0] sink;
   logic [3:0] prev = 4'h0;
   logic reg_on, seq, ovl, stop, lreq;
   int fails = 0;
   int total_checks = 0;
   int cyc = 0;
   int rise[4];
   int offs[6][4] = '{'{0, 12, 24, 36}, '{0, 16, 32, -1}, '{0, -1, 24, -1},
                      '{0, 0, 24, 24}, '{0, 0, -1, -1}, '{0, 0, 0, 0}};
   logic [3:0] cfg[6] = '{4'hF, 4'h7, 4'h5, 4'hF, 4'h3, 4'hF};

   lds_ctrl_model pm (.clk_in(clk), .run_in(run), .level_in(lvl), .enable_in(en),
      .period_in(8'(P)), .high_in(8'h08), .dim_out(dim), .enable_out(ena),
      .analog_duty_out());
   lds_sequencer #(.MIN_PERIOD_CYC(50)) dut (.CLK_IN(clk), .RESET_N_IN(rst_n),
      .BACKLIGHT_ON_REQUEST_IN(ena), .DIGITAL_DIM_INPUT_IN(dim),
      .DIM_LEVEL_PIN_HIGH_IN(pin_hi), .SEQUENCE_SELECT_RESISTOR_IN(seq_res),
      .FACTORY_SEQUENCE_PRESET_IN(fact), .HYBRID_STRAP_IN(hyb),
      .LATCH_OFF_OPTION_IN(latch), .STRAPS_VALID_IN(valid),
      .STRINGS_PRESENT_IN(strings), .GANGED_PAIRS_IN(gang), .SW_CYCLE_IN(swc),
      .FIXED_RAIL_1_LOW_IN(rail[0]), .FIXED_RAIL_2_LOW_IN(rail[1]),
      .STRING_SUPPLY_RAIL_LOW_IN(rail[2]), .STRING_SINK_OUT(sink),
      .REGULATOR_ON_OUT(reg_on), .SEQUENCED_OUT(seq), .OVERLOAD_OUT(ovl),
      .STOP_REQUESTS_OUT(stop), .LATCH_OFF_REQUEST_OUT(lreq));

   always #50 clk = ~clk;

   always @(posedge clk) begin
      cyc <= cyc + 1;
      prev <= sink;
      for (int i = 0; i < 4; i++) begin
         if (!rst_n) begin
            rise[i] <= -1;
         end else if (sink[i] === 1'b1 && prev[i] === 1'b0) begin
            rise[i] <= cyc;
         end
      end
      // well above the few thousand cycles the tests need
      if (cyc == 20000) begin
         fails++;
         test_done();
      end
   end

   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : settle

   task automatic boot(input logic [3:0] s, input logic ph, sr, fa, hy, g, la);
      @(posedge clk);
      rst_n <= 1'b0;
      valid <= 1'b0;
      {strings, pin_hi, seq_res, fact, hyb, gang, latch} <= {s, ph, sr, fa, hy, g, la};
      {run, lvl, en, rail} <= {3'b001, 3'h0};
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      valid <= 1'b1;
      settle(3);
   endtask : boot

   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge clk) swc <= 1'b1;
         repeat (3) @(posedge clk);
         swc <= 1'b0;
         repeat (3) @(posedge clk);
      end
   endtask : pulse

   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : test_done

   initial begin
      boot(4'hF, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      @(posedge clk) lvl <= 1'b1;
      settle(4);
      chk("sinks on", 8'(sink), 8'h0F);
      chk("regulator on", 8'(reg_on), 8'h01);
      @(posedge clk) en <= 1'b0;
      settle(4);
      chk("enable off sinks", 8'(sink), 8'h00);
      chk("enable off regulator", 8'(reg_on), 8'h00);
      @(posedge clk) {en, lvl} <= 2'b10;
      settle(10);
      chk("short low regulator", 8'(reg_on), 8'h01);
      settle(50);
      chk("long low regulator", 8'(reg_on), 8'h00);
      $display("test normal gating done");
      for (int t = 0; t < 6; t++) begin
         boot(cfg[t], 1'b1, t < 5, 1'b0, 1'b0, t == 3, 1'b0);
         @(posedge clk) run <= 1'b1;
         settle(5 * P);
         chk("sequenced flag", 8'(seq), 8'(t < 4));
         for (int i = 0; i < 4; i++)
            chk("sink phase", rise[i] < 0 ? 8'hFF : 8'((rise[i] - rise[0] + 5 * P) % P),
               8'(offs[t][i]));
      end
      $display("test sequencing done");
      boot(4'hF, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
      chk("hybrid default", 8'(seq), 8'h00);
      @(posedge clk) lvl <= 1'b1;
      settle(4);
      chk("hybrid sinks on", 8'(sink), 8'h0F);
      @(posedge clk) lvl <= 1'b0;
      settle(4);
      chk("hybrid sinks off", 8'(sink), 8'h00);
      settle(60);
      chk("hybrid regulator", 8'(reg_on), 8'h00);
      boot(4'hF, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
      chk("hybrid preset", 8'(seq), 8'h01);
      @(posedge clk) {fact, pin_hi} <= 2'b01;
      settle(4);
      chk("mode held", 8'(seq), 8'h01);
      boot(4'hF, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      @(posedge clk) lvl <= 1'b1;
      settle(4);
      chk("analog sinks on", 8'(sink), 8'h0F);
      @(posedge clk) lvl <= 1'b0;
      settle(4);
      chk("analog all off", 8'({reg_on, sink}), 8'h00);
      $display("test dimming modes done");
      for (int r = 0; r < 3; r++) begin
         boot(4'hF, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, r[0]);
         @(posedge clk) rail <= 3'h1 << r;
         pulse(32);
         settle(6);
         chk("no overload at limit", 8'(ovl), 8'h00);
         pulse(1);
         settle(8);
         chk("overload", 8'(ovl), 8'h01);
         chk("fault response", 8'({stop, lreq}), r[0] ? 8'h01 : 8'h02);
      end
      $display("test overload done");
      test_done();
   end
endmodule : tb_led_string_dimming_sequencer
